// [bench/core_model.sv]
// behavioural core that takes the delivered interrupt
`timescale 1ns/1ps
`default_nettype none
module core_model
	import intc_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// delivery from the block
	input wire logic i_deliver,
	input wire logic [VEC_W-1:0] i_vector,
	// take strobes back
	output logic [SRC_CNT-1:0] o_take
);
	initial begin
		o_take = 7'h00;
		forever begin
			@(posedge i_clock);
			if (i_rst_n === 1'b1 && i_deliver === 1'b1) begin
				o_take <= 7'h01 << i_vector;
				@(posedge i_clock);
				o_take <= 7'h00;
				// stale delivery lingers a few edges after a take
				repeat (3) @(posedge i_clock);
			end
		end
	end
endmodule : core_model
`default_nettype wire

// [bench/interrupt_post_mask_logic_tb_top.sv]
// self-checking bench for the group-2 posting and masking block
`timescale 1ns/1ps
`default_nettype none
module interrupt_post_mask_logic_tb_top import intc_pkg::*;;
	logic clk, rst_n, cyc, stb, we, global_irq_enable, ack, deliver, irq;
	logic [ADDR_W-1:0] adr;
	logic [3:0] sel;
	logic [DATA_W-1:0] wdat, rdat;
	logic [SRC_CNT-1:0] src, take, pend, m_post, m_mask;
	logic [VEC_W-1:0] vec;
	logic [31:0] r;
	logic [7:0] q;
	logic [15:0] m01;
	logic m_swen;
	int n_fail, num_checks;
	localparam logic [9:0] A_POST = 10'h370, A_SW = 10'h378, A_MSK = 10'h37c;
	localparam logic [9:0] A_M1 = 10'h384, A_ST = 10'h388, A_IM = 10'h38c;
	localparam logic [9:0] A_M0 = 10'h380;

	interrupt_post_mask_logic dut_u (
		.I_CLOCK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
		.O_WB_ACK(ack), .O_WB_DAT(rdat), .I_SOURCE_EVENT(src),
		.I_TAKE(take), .I_GLOBAL_IRQ_ENABLE(global_irq_enable), .O_PENDING(pend),
		.O_DELIVER(deliver), .O_VECTOR(vec), .O_IRQ(irq));
	core_model core_u (.i_clock(clk), .i_rst_n(rst_n), .i_deliver(deliver),
		.i_vector(vec), .o_take(take));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [31:0] e,
			input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask : chk

	// one classic cycle; source events drop at the ack edge
	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 16);
		if (n >= 16) begin
			n_fail++;
			complete_run();
		end else begin
			q = rdat[7:0];
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
			src <= 7'h00;
		end
	endtask : wb

	task automatic rd(input string what, input logic [9:0] a,
			input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(what, {24'h0, e}, {24'h0, q});
	endtask : rd

	function automatic logic [6:0] post_after(logic [6:0] p, logic [6:0] d,
			logic en);
		return en ? (p | d) : (p & d);
	endfunction : post_after

	task automatic settle;
		repeat (3) @(posedge clk);
	endtask : settle

	initial begin
		{cyc, stb, we, global_irq_enable, rst_n} = 5'h00;
		adr = 10'h000;
		sel = 4'h0;
		wdat = 32'h0;
		src = 7'h00;
		{m_post, m_mask, m_swen} = 15'h0000;
		n_fail = 0;
		num_checks = 0;
		void'($urandom(32'h4fce));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd("posted", A_POST, 8'h00);
		rd("swctrl", A_SW, 8'h00);
		rd("mask2", A_MSK, 8'h00);
		rd("mask1", A_M1, 8'h00);
		wb(1'b1, 10'h3fc, 8'hff);
		rd("unmapped", 10'h3fc, 8'h00);
		r = $urandom;
		m01 = r[15:0];
		wb(1'b1, A_M0, m01[7:0]);
		wb(1'b1, A_M1, m01[15:8]);
		rd("mask0", A_M0, m01[7:0]);
		for (int i = 0; i < 60; i++) begin
			r = $urandom;
			case (r[1:0])
			2'd0: begin
				m_swen = r[8];
				wb(1'b1, A_SW, {r[8], r[15:9]});
				wb(1'b1, A_POST, r[23:16]);
				m_post = post_after(m_post, r[22:16], m_swen);
			end
			2'd1: begin
				wb(1'b1, A_MSK, r[23:16]);
				m_mask = r[22:16];
			end
			default: begin
				@(posedge clk);
				src <= r[22:16];
				@(posedge clk);
				src <= 7'h00;
				m_post = m_post | r[22:16];
			end
			endcase
			settle();
			chk("pending", m_post & m_mask, pend);
			rd("posted", A_POST, {1'b0, m_post});
			rd("swctrl", A_SW, {m_swen, 7'h00});
			rd("mask2", A_MSK, {1'b0, m_mask});
		end
		// core takes bits 3 then 5 once global enable rises
		wb(1'b1, A_SW, 8'h00);
		wb(1'b1, A_POST, 8'h00);
		wb(1'b1, A_SW, 8'h80);
		wb(1'b1, A_POST, 8'h28);
		wb(1'b1, A_MSK, 8'h7f);
		settle();
		chk("vector", 32'h3, vec);
		chk("deliver", 32'h0, deliver);
		@(posedge clk);
		global_irq_enable <= 1'b1;
		repeat (2) @(posedge clk);
		chk("deliver", 32'h1, deliver);
		repeat (4) @(posedge clk);
		chk("vector", 32'h5, vec);
		repeat (14) @(posedge clk);
		rd("posted", A_POST, 8'h00);
		global_irq_enable <= 1'b0;
		// hardware post beats a same-edge software clear
		wb(1'b1, A_SW, 8'h00);
		@(posedge clk);
		src <= 7'h01;
		wb(1'b1, A_POST, 8'h00);
		rd("posted", A_POST, 8'h01);
		wb(1'b1, A_ST, 8'h7f);
		wb(1'b1, A_IM, 8'h7f);
		settle();
		chk("irq", 32'h0, irq);
		@(posedge clk);
		src <= 7'h04;
		@(posedge clk);
		src <= 7'h00;
		settle();
		chk("irq", 32'h1, irq);
		rd("status", A_ST, 8'h04);
		wb(1'b1, A_IM, 8'h00);
		settle();
		chk("irq", 32'h0, irq);
		wb(1'b1, A_ST, 8'h04);
		rd("status", A_ST, 8'h00);
		rd("mask0", A_M0, m01[7:0]);
		rd("mask1", A_M1, m01[15:8]);
		complete_run();
	end
endmodule : interrupt_post_mask_logic_tb_top
`default_nettype wire

// [rtl/intc_pkg.sv]
// constants for the group-2 interrupt posting and masking block
// Contract
// R1 - reading posted flags returns 1 where a source is posted, else 0
// R2 - with software post off, writing 0 clears that posted flag
// R3 - with software post off, writing 1 leaves the posted flag alone
// R4 - with software post on, written 0 bits are ignored
// R5 - with software post on, writing 1 posts that source like hardware
// R6 - posted flag with mask bit 0 is not pending
// R7 - hardware condition still posts while its mask bit is 0
// R8 - posted flag with mask bit 1 is pending toward the encoder
// R9 - each mask bit acts only on its own source, writes touch no other
// R10 - four mask registers exist, 0 masks and 1 unmasks
// R11 - software post enable is bit 7 at 0xde, reset 0, bits 6:0 reserved
// R12 - posted flags at 0xdc: capture1,wrap,ext2,datalow,port2,port3; reset 0
// R13 - mask at 0xdf uses same bit positions, reset 0, bit 7 reserved
// R14 - bit 6 of mask at 0xdf enables the port 4 interrupt
// R15 - mask value 0 masks the source, 1 unmasks it
// R16 - posted flag stays set until taken by core or cleared by software
// R17 - highest pending is delivered only while global enable is set
// R18 - hardware post in the same cycle as a software clear wins
package intc_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 10;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = ADDR_W - IDX_LSB;
	localparam int REG_W = 8;
	localparam int SRC_CNT = 7;
	localparam int VEC_W = 3;
	// register indexes, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_POSTED2 = 8'hdc;
	localparam logic [IDX_W-1:0] IDX_SWCTRL = 8'hde;
	localparam logic [IDX_W-1:0] IDX_MASK2 = 8'hdf;
	localparam logic [IDX_W-1:0] IDX_MASK0 = 8'he0;
	localparam logic [IDX_W-1:0] IDX_MASK1 = 8'he1;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'he2;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'he3;
	// field positions
	localparam int SWPOST_BIT = 7;
	localparam int SRC_CAPTURE1 = 0;
	localparam int SRC_WRAP = 1;
	localparam int SRC_EXT2 = 2;
	localparam int SRC_DATA_LOW = 3;
	localparam int SRC_PORT2 = 4;
	localparam int SRC_PORT3 = 5;
	localparam int SRC_PORT4 = 6;
	// reset values
	localparam logic [SRC_CNT-1:0] RST_SRC = 7'h00;
	localparam logic [REG_W-1:0] RST_REG = 8'h00;
	localparam logic [VEC_W-1:0] RST_VEC = 3'h0;
endpackage : intc_pkg

// [rtl/interrupt_post_mask_logic.sv]
// group-2 interrupt posting, masking and delivery with wishbone registers
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module interrupt_post_mask_logic
	import intc_pkg::*;
(
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	// wishbone slave
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [ADDR_W-1:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [DATA_W-1:0] I_WB_DAT,
	output logic O_WB_ACK,
	output logic [DATA_W-1:0] O_WB_DAT,
	// interrupt sources and core side
	input wire logic [SRC_CNT-1:0] I_SOURCE_EVENT,
	input wire logic [SRC_CNT-1:0] I_TAKE,
	input wire logic I_GLOBAL_IRQ_ENABLE,
	// pending and delivery
	output logic [SRC_CNT-1:0] O_PENDING,
	output logic O_DELIVER,
	output logic [VEC_W-1:0] O_VECTOR,
	// summary interrupt
	output logic O_IRQ
);

	logic [SRC_CNT-1:0] posted;
	logic [SRC_CNT-1:0] mask2;
	logic software_post_enable;
	logic [REG_W-1:0] mask0;
	logic [REG_W-1:0] mask1;
	logic [SRC_CNT-1:0] irq_status;
	logic [SRC_CNT-1:0] irq_mask;
	logic [SRC_CNT-1:0] next_posted;
	logic [SRC_CNT-1:0] next_status;

	// bus decode
	wire logic bus_req = I_WB_CYC & I_WB_STB;
	wire logic new_req = bus_req & ~O_WB_ACK;
	wire logic wr_lane = bus_req & O_WB_ACK & I_WB_WE & I_WB_SEL[0];
	wire logic [IDX_W-1:0] adr_idx = I_WB_ADR[ADDR_W-1:IDX_LSB];
	wire logic hit_posted = adr_idx == IDX_POSTED2;
	wire logic hit_swctrl = adr_idx == IDX_SWCTRL;
	wire logic hit_mask2 = adr_idx == IDX_MASK2;
	wire logic hit_mask0 = adr_idx == IDX_MASK0;
	wire logic hit_mask1 = adr_idx == IDX_MASK1;
	wire logic hit_status = adr_idx == IDX_IRQ_STATUS;
	wire logic hit_irq_mask = adr_idx == IDX_IRQ_MASK;
	wire logic hit_any = hit_posted | hit_swctrl | hit_mask2 |
		hit_mask0 | hit_mask1 | hit_status |
		hit_irq_mask;
	wire logic wr_posted = wr_lane & hit_posted;
	wire logic wr_swctrl = wr_lane & hit_swctrl;
	wire logic wr_mask2 = wr_lane & hit_mask2;
	wire logic wr_mask0 = wr_lane & hit_mask0;
	wire logic wr_mask1 = wr_lane & hit_mask1;
	wire logic wr_status = wr_lane & hit_status;
	wire logic wr_irq_mask = wr_lane & hit_irq_mask;
	wire logic [SRC_CNT-1:0] wdata_src = I_WB_DAT[SRC_CNT-1:0];

	// software set and clear vectors, steered by the post enable
	wire logic [SRC_CNT-1:0] sw_set =
		(wr_posted & software_post_enable) ? wdata_src : RST_SRC; // [R5]
	wire logic [SRC_CNT-1:0] sw_clr =
		(wr_posted & ~software_post_enable) ? ~wdata_src : RST_SRC; // [R2] [R3] [R4]
	wire logic [SRC_CNT-1:0] post_set = I_SOURCE_EVENT | sw_set; // [R7]
	wire logic [SRC_CNT-1:0] post_clr = sw_clr | I_TAKE; // [R16]
	wire logic [SRC_CNT-1:0] post_rise = post_set & ~posted;
	wire logic [SRC_CNT-1:0] pending_vec = posted & mask2; // [R6] [R8] [R15]

	// read mux
	wire logic [REG_W-1:0] rd_posted = {1'b0, posted}; // [R1] [R12]
	wire logic [REG_W-1:0] rd_swctrl =
		{software_post_enable, 7'h00}; // [R11]
	wire logic [REG_W-1:0] rd_mask2 = {1'b0, mask2}; // [R13] [R14]
	wire logic [REG_W-1:0] rd_status = {1'b0, irq_status};
	wire logic [REG_W-1:0] rd_irq_mask = {1'b0, irq_mask};
	wire logic [REG_W-1:0] rd_byte =
		hit_posted ? rd_posted :
		hit_swctrl ? rd_swctrl :
		hit_mask2 ? rd_mask2 :
		hit_mask0 ? mask0 :
		hit_mask1 ? mask1 :
		hit_status ? rd_status :
		hit_irq_mask ? rd_irq_mask : RST_REG;
	wire logic [DATA_W-1:0] rd_word = {{(DATA_W-REG_W){1'b0}}, rd_byte};

	// lowest index wins the encoder
	function automatic logic [VEC_W-1:0] prio(input logic [SRC_CNT-1:0] v);
		logic [VEC_W-1:0] r;
		r = RST_VEC;
		for (int k = SRC_CNT - 1; k >= 0; k--) begin
			if (v[k]) begin
				r = VEC_W'(k);
			end
		end
		return r;
	endfunction : prio

	// per-source posted flag and event status; set beats clear
	genvar g;
	generate
		for (g = 0; g < SRC_CNT; g++) begin : g_src
			assign next_posted[g] =
				post_set[g] | (posted[g] & ~post_clr[g]); // [R18] [R16]
			assign next_status[g] = (post_set[g] & ~posted[g]) |
				(irq_status[g] & ~(wr_status & wdata_src[g]));
		end
	endgenerate

	// bus answer: ack one cycle after the request, then drop
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_WB_ACK <= 1'b0;
			O_WB_DAT <= '0;
		end else begin
			O_WB_ACK <= new_req;
			if (new_req) begin
				O_WB_DAT <= rd_word;
			end
		end
	end

	// posted flags and event status
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			posted <= RST_SRC; // [R12]
			irq_status <= RST_SRC;
		end else begin
			posted <= next_posted;
			irq_status <= next_status;
		end
	end

	// control and mask registers, each written only by its own decode
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			software_post_enable <= 1'b0; // [R11]
			mask2 <= RST_SRC; // [R13]
			mask0 <= RST_REG;
			mask1 <= RST_REG;
			irq_mask <= RST_SRC;
		end else begin
			if (wr_swctrl) begin
				software_post_enable <= I_WB_DAT[SWPOST_BIT]; // [R11]
			end
			if (wr_mask2) begin
				mask2 <= wdata_src; // [R9] [R10] [R14]
			end
			if (wr_mask0) begin
				mask0 <= I_WB_DAT[REG_W-1:0]; // [R10]
			end
			if (wr_mask1) begin
				mask1 <= I_WB_DAT[REG_W-1:0]; // [R10]
			end
			if (wr_irq_mask) begin
				irq_mask <= wdata_src;
			end
		end
	end

	// pending vector, delivery and summary interrupt
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PENDING <= RST_SRC;
			O_DELIVER <= 1'b0;
			O_VECTOR <= RST_VEC;
			O_IRQ <= 1'b0;
		end else begin
			O_PENDING <= pending_vec; // [R6] [R8]
			O_DELIVER <= (|pending_vec) & I_GLOBAL_IRQ_ENABLE; // [R17]
			O_VECTOR <= prio(pending_vec);
			O_IRQ <= |(irq_status & irq_mask);
		end
	end

	// checks
	// pending bits of higher priority than the presented vector
	wire logic [SRC_CNT-1:0] below_vec =
		(SRC_CNT'(1) << O_VECTOR) - SRC_CNT'(1);
	sequence s_rd_posted;
		new_req & ~I_WB_WE & hit_posted;
	endsequence

	sequence s_ack_pulse;
		O_WB_ACK ##1 !O_WB_ACK;
	endsequence

	property p_read_posted;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		s_rd_posted |=> O_WB_DAT == {{(DATA_W-SRC_CNT){1'b0}}, $past(posted)};
	endproperty
	a_read_posted: assert property (p_read_posted) // [R1] [R12]
		else $error("posted flag read value wrong");

	property p_ack_once;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		new_req |=> s_ack_pulse;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack not a single pulse after request");

	property p_sw_clear;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(wr_posted & ~software_post_enable & ~|I_SOURCE_EVENT & ~|I_TAKE)
		|=> posted == ($past(posted) & $past(wdata_src));
	endproperty
	a_sw_clear: assert property (p_sw_clear) // [R2] [R3]
		else $error("software clear result wrong");

	property p_sw_post;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(wr_posted & software_post_enable & ~|I_SOURCE_EVENT & ~|I_TAKE)
		|=> posted == ($past(posted) | $past(wdata_src));
	endproperty
	a_sw_post: assert property (p_sw_post) // [R4] [R5]
		else $error("software post result wrong");

	property p_hw_post;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		|I_SOURCE_EVENT |=> (posted & $past(I_SOURCE_EVENT)) ==
			$past(I_SOURCE_EVENT);
	endproperty
	a_hw_post: assert property (p_hw_post) // [R7] [R18]
		else $error("hardware event lost");

	property p_take;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(|I_TAKE & ~|I_SOURCE_EVENT & ~wr_posted)
		|=> posted == ($past(posted) & ~$past(I_TAKE));
	endproperty
	a_take: assert property (p_take) // [R16]
		else $error("taken interrupt not cleared");

	property p_hold;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(~|I_TAKE & ~wr_posted) |=> (posted & $past(posted)) == $past(posted);
	endproperty
	a_hold: assert property (p_hold) // [R16]
		else $error("posted flag dropped without clear");

	property p_pending;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		##1 O_PENDING == ($past(posted) & $past(mask2));
	endproperty
	a_pending: assert property (p_pending) // [R6] [R8]
		else $error("pending does not follow posted and mask");

	property p_mask_own;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		wr_mask2 |=> $stable(mask1) && $stable(mask0) &&
			$stable(software_post_enable) && mask2 == $past(wdata_src);
	endproperty
	a_mask_own: assert property (p_mask_own) // [R9]
		else $error("mask write disturbed another register");

	property p_deliver;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		O_DELIVER |-> $past(I_GLOBAL_IRQ_ENABLE) && (|O_PENDING);
	endproperty
	a_deliver: assert property (p_deliver) // [R17]
		else $error("delivery without global enable");

	property p_ctrl_reserved;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(new_req & ~I_WB_WE & hit_swctrl) |=>
			O_WB_DAT[SWPOST_BIT-1:0] == 7'h00;
	endproperty
	a_ctrl_reserved: assert property (p_ctrl_reserved) // [R11]
		else $error("reserved control bits read nonzero");

	property p_irq;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		##1 O_IRQ == |($past(irq_status) & $past(irq_mask));
	endproperty
	a_irq: assert property (p_irq)
		else $error("summary interrupt wrong");

	property p_status_set;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		|post_rise |=> (irq_status & $past(post_rise)) == $past(post_rise);
	endproperty
	a_status_set: assert property (p_status_set)
		else $error("event status not set by a new posting");

	property p_status_clear;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(wr_status & ~|post_rise) |=>
			irq_status == ($past(irq_status) & ~$past(wdata_src));
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("event status write-one-clear wrong");

	property p_vector_prio;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(O_PENDING != RST_SRC) |->
			O_PENDING[O_VECTOR] && ((O_PENDING & below_vec) == RST_SRC);
	endproperty
	a_vector_prio: assert property (p_vector_prio) // [R8]
		else $error("vector not the lowest pending source");

	property p_vector_idle;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(O_PENDING == RST_SRC) |-> (O_VECTOR == RST_VEC) && !O_DELIVER;
	endproperty
	a_vector_idle: assert property (p_vector_idle) // [R6]
		else $error("vector or delivery without a pending source");

	property p_deliver_on;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(|pending_vec & I_GLOBAL_IRQ_ENABLE) |=> O_DELIVER;
	endproperty
	a_deliver_on: assert property (p_deliver_on) // [R8] [R17]
		else $error("pending source with global enable not delivered");

	property p_unmapped_read;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(new_req & ~I_WB_WE & ~hit_any) |=> O_WB_DAT == '0;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read returned nonzero");

	property p_store_hold;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		(~wr_mask0 & ~wr_mask1 & ~wr_mask2 & ~wr_swctrl) |=>
			$stable(mask0) && $stable(mask1) && $stable(mask2) &&
			$stable(software_post_enable);
	endproperty
	a_store_hold: assert property (p_store_hold) // [R9] [R10]
		else $error("control or mask register changed without a write");

	property p_ack_idle;
		@(posedge I_CLOCK) disable iff (!I_RST_N)
		!bus_req |=> !O_WB_ACK;
	endproperty
	a_ack_idle: assert property (p_ack_idle)
		else $error("ack without a request");

endmodule : interrupt_post_mask_logic
`default_nettype wire
